// ---- rtl/dms_core.sv ----
// dual mode serial core: async character mode and 3-wire clocked mode
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dms_params.svh"

module dms_core (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic async_receive_pin_i,
  output logic async_transmit_pin_o,
  input wire logic clocked_data_in_i,
  output logic clocked_data_out_o,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o
);
  import dms_pkg::*;

  dms_state_t st_reg;
  dms_state_t st_next;
  logic rxd_s, si_s, sck_s, tick, baud_run, wr_acc, rd_snap, wr_data;
  logic rx_done, has_par, par_bit, sck_cur, sck_rise, sck_fall;
  logic [1:0] ps;
  logic [3:0] nbits;
  logic [3:0] tx_total;
  logic [7:0] wd;
  logic [7:0] tx_data;
  logic [7:0] rd_val;
  logic [11:0] frame;
  logic [2:0] cs_pos;

  // ----------------------------------------------------------------
  // pin synchronisers and baud tick
  // ----------------------------------------------------------------
  dms_sync u_sync_rxd (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(async_receive_pin_i), .q_o(rxd_s));
  dms_sync u_sync_si (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(clocked_data_in_i), .q_o(si_s));
  dms_sync u_sync_sck (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .d_i(serial_clock_pin_i), .q_o(sck_s));

  assign baud_run = st_reg.am[`DMS_AM_TXE] | st_reg.am[`DMS_AM_RXE]
                  | (st_reg.cm[`DMS_CM_EN] & st_reg.cm[`DMS_CM_SRC]);

  dms_baud u_baud (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .run_i(baud_run), .div_i(st_reg.bg), .tick_o(tick));

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // read side effects happen at the snapshot edge so that an event
  // landing between snapshot and acceptance is never cleared unseen
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_reg.ack;
  assign wr_acc = avs_write_i & st_reg.ack & avs_byteenable_i[0];
  assign rd_snap = avs_read_i & ~st_reg.ack;
  assign wr_data = wr_acc & (avs_address_i == `DMS_IDX_DATA);
  assign wd = avs_writedata_i[7:0];

  always_comb begin
    case (avs_address_i)
      `DMS_IDX_ASYNC: rd_val = st_reg.am;
      `DMS_IDX_STATUS: rd_val = {5'h00, st_reg.es};
      `DMS_IDX_CLOCKED: rd_val = st_reg.cm;
      `DMS_IDX_DATA: rd_val = st_reg.rxb;
      `DMS_IDX_BAUD: rd_val = st_reg.bg;
      default: rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // frame builder and helpers
  // ----------------------------------------------------------------
  assign ps = st_reg.am[`DMS_AM_PSH:`DMS_AM_PSL];
  assign has_par = (ps != 2'h0);
  assign nbits = st_reg.am[`DMS_AM_CL] ? 4'h8 : 4'h7;
  assign tx_total = 4'h1 + nbits + {3'h0, has_par}
                  + (st_reg.am[`DMS_AM_SL] ? 4'h2 : 4'h1);
  assign tx_data = st_reg.am[`DMS_AM_CL] ? wd : {1'b0, wd[6:0]};

  always_comb begin
    case (ps)
      2'h1: par_bit = 1'b0;
      2'h2: par_bit = ~^tx_data;
      default: par_bit = ^tx_data;
    endcase
    // trailing ones double as stop bits
    frame = 12'hfff;
    frame[0] = 1'b0;
    frame[8:1] = tx_data;
    if (!st_reg.am[`DMS_AM_CL]) begin
      frame[8] = 1'b1;
    end
    if (has_par) begin
      frame[nbits + 4'h1] = par_bit;
    end
  end

  assign rx_done = (st_reg.rx_st == RX_STOP) & tick
                 & (st_reg.rx_os == `DMS_OS_LAST);
  assign sck_cur = st_reg.cm[`DMS_CM_SRC] ? st_reg.sck : sck_s;
  assign sck_rise = ~st_reg.sck_prev & sck_cur;
  assign sck_fall = st_reg.sck_prev & ~sck_cur;
  assign cs_pos = st_reg.cm[`DMS_CM_DIR] ? st_reg.cs_k[2:0]
                : 3'h7 - st_reg.cs_k[2:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ack = (avs_read_i | avs_write_i) & ~st_reg.ack;
    st_next.sck_prev = sck_cur;

    if (rd_snap) begin
      st_next.rd = rd_val;
      if (avs_address_i == `DMS_IDX_STATUS) begin
        st_next.es = 3'h0;
      end
      if (avs_address_i == `DMS_IDX_DATA) begin
        st_next.rx_full = 1'b0;
      end
    end

    if (wr_acc) begin
      case (avs_address_i)
        `DMS_IDX_ASYNC: st_next.am = wd;
        `DMS_IDX_CLOCKED: st_next.cm = wd;
        `DMS_IDX_BAUD: st_next.bg = wd;
        `DMS_IDX_DATA: st_next.txs = wd;
        default: st_next.bg = st_reg.bg;
      endcase
    end

    // async transmitter
    if (!st_reg.am[`DMS_AM_TXE]) begin
      st_next.tx_busy = 1'b0;
      st_next.txd = 1'b1;
    end else if (st_reg.tx_busy) begin
      if (tick) begin
        st_next.tx_os = st_reg.tx_os + 4'h1;
        if (st_reg.tx_os == `DMS_OS_LAST) begin
          st_next.tx_sh = {1'b1, st_reg.tx_sh[11:1]};
          st_next.tx_left = st_reg.tx_left - 4'h1;
          st_next.txd = st_reg.tx_sh[1];
          if (st_reg.tx_left == 4'h1) begin
            st_next.tx_busy = 1'b0;
            st_next.txd = 1'b1;
          end
        end
      end
    end else if (wr_data && !st_reg.cm[`DMS_CM_EN]) begin
      st_next.tx_busy = 1'b1;
      st_next.tx_sh = frame;
      st_next.tx_left = tx_total;
      st_next.tx_os = 4'h0;
      st_next.txd = frame[0];
    end

    // async receiver
    if (!st_reg.am[`DMS_AM_RXE]) begin
      st_next.rx_st = RX_IDLE;
    end else begin
      if (tick && st_reg.rx_st != RX_IDLE) begin
        st_next.rx_os = st_reg.rx_os + 4'h1;
      end
      case (st_reg.rx_st)
        RX_IDLE: begin
          if (!rxd_s) begin
            st_next.rx_st = RX_START;
            st_next.rx_os = 4'h0;
          end
        end
        RX_START: begin
          // a glitch shorter than half a bit is not a start
          if (tick && st_reg.rx_os == `DMS_OS_MID) begin
            st_next.rx_os = 4'h0;
            st_next.rx_idx = 4'h0;
            st_next.rx_sh = 8'h00;
            st_next.rx_par = 1'b0;
            st_next.rx_st = rxd_s ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (tick && st_reg.rx_os == `DMS_OS_LAST) begin
            st_next.rx_sh[st_reg.rx_idx[2:0]] = rxd_s;
            st_next.rx_par = st_reg.rx_par ^ rxd_s;
            st_next.rx_idx = st_reg.rx_idx + 4'h1;
            if (st_reg.rx_idx == nbits - 4'h1) begin
              st_next.rx_st = has_par ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (tick && st_reg.rx_os == `DMS_OS_LAST) begin
            st_next.rx_par = st_reg.rx_par ^ rxd_s;
            st_next.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_done) begin
            st_next.rx_st = RX_IDLE;
            st_next.rxb = st_reg.am[`DMS_AM_CL] ? st_reg.rx_sh
                        : {1'b0, st_reg.rx_sh[6:0]};
            st_next.rx_full = 1'b1;
            // flag sets come after the read clear, so a set wins
            if (!rxd_s) begin
              st_next.es[`DMS_ES_FE] = 1'b1;
            end
            if (ps[1] && (ps[0] ? st_reg.rx_par : ~st_reg.rx_par)) begin
              st_next.es[`DMS_ES_PE] = 1'b1;
            end
            if (st_reg.rx_full) begin
              st_next.es[`DMS_ES_OV] = 1'b1;
            end
          end
        end
        default: st_next.rx_st = RX_IDLE;
      endcase
    end

    // clocked 3-wire engine
    if (!st_reg.cm[`DMS_CM_EN]) begin
      st_next.cs_busy = 1'b0;
      st_next.sck = 1'b1;
    end else if (st_reg.cs_busy) begin
      // no toggle on the cycle the last rise is seen: sck stays high
      if (st_reg.cm[`DMS_CM_SRC] && tick && !sck_rise) begin
        st_next.sck = ~st_reg.sck;
      end
      if (sck_rise) begin
        st_next.rx_sh[cs_pos] = si_s;
        st_next.cs_k = st_reg.cs_k + 4'h1;
        if (st_reg.cs_k == 4'h7) begin
          st_next.cs_busy = 1'b0;
          st_next.rxb = st_next.rx_sh;
          st_next.rx_full = 1'b1;
        end
      end else if (sck_fall) begin
        st_next.so = st_reg.txs[cs_pos];
      end
    end else if (wr_data) begin
      st_next.cs_busy = 1'b1;
      st_next.cs_k = 4'h0;
      st_next.sck = 1'b1;
      st_next.so = st_reg.cm[`DMS_CM_DIR] ? wd[0] : wd[7];
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // the receive buffer is cleared only because the struct is; software
  // must not rely on its value before the first character
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.am <= `DMS_ASYNC_RST;
      st_reg.cm <= `DMS_CLOCKED_RST;
      st_reg.bg <= `DMS_BAUD_RST;
      st_reg.txs <= `DMS_TXS_RST;
      st_reg.txd <= 1'b1;
      st_reg.sck <= 1'b1;
      st_reg.sck_prev <= 1'b1;
      st_reg.so <= 1'b1;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_o = {24'h00_0000, st_reg.rd};
  assign async_transmit_pin_o = st_reg.txd;
  assign clocked_data_out_o = st_reg.so;
  assign serial_clock_pin_o = st_reg.sck;
  assign serial_clock_pin_oe_o = st_reg.cm[`DMS_CM_EN]
                               & st_reg.cm[`DMS_CM_SRC];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking dms_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i | ~ce_i);

  AST_RESET_VALUES: assert property (
    $fell(rst_i) |-> st_reg.txs == `DMS_TXS_RST
      && st_reg.am == `DMS_ASYNC_RST && st_reg.cm == `DMS_CLOCKED_RST
  ) else $error("register reset values wrong");

  AST_TX_START: assert property (
    wr_data && st_reg.am[`DMS_AM_TXE] && !st_reg.cm[`DMS_CM_EN]
      && !st_reg.tx_busy
    |=> st_reg.tx_busy && !async_transmit_pin_o && st_reg.tx_left == tx_total
  ) else $error("write did not start a frame with a start bit");

  AST_TX_IDLE_HIGH: assert property (
    !st_reg.tx_busy |-> async_transmit_pin_o
  ) else $error("transmit line not high while idle");

  AST_RX_SEVEN: assert property (
    rx_done && !st_reg.am[`DMS_AM_CL] |=> !st_reg.rxb[7]
  ) else $error("seven-bit receive left bit 7 set");

  AST_SHARED_READ: assert property (
    rd_snap && avs_address_i == `DMS_IDX_DATA
    |=> avs_readdata_o[7:0] == $past(st_reg.rxb) && !avs_waitrequest_o
  ) else $error("data address read not from receive buffer");

  AST_WRITE_TXS: assert property (
    wr_data && st_reg.rx_st != RX_STOP && !st_reg.cs_busy
    |=> st_reg.txs == $past(wd) && $stable(st_reg.rxb)
  ) else $error("data write hit receive buffer");

  AST_OVERRUN: assert property (
    rx_done && st_reg.rx_full |=> st_reg.es[`DMS_ES_OV] && st_reg.rx_full
  ) else $error("overrun not flagged");

  AST_ZERO_PARITY: assert property (
    rx_done && ps == 2'h1 && !st_reg.es[`DMS_ES_PE]
    |=> !st_reg.es[`DMS_ES_PE]
  ) else $error("parity checked in zero-parity mode");

  AST_CS_EIGHT: assert property (
    st_reg.cs_busy && sck_rise && st_reg.cs_k == 4'h7
    |=> !st_reg.cs_busy && st_reg.rx_full ##1 serial_clock_pin_o
  ) else $error("clocked transfer did not end after eight bits");

  COV_TX_FRAME: cover property ($fell(st_reg.tx_busy));
  COV_RX_DONE: cover property (rx_done);
  COV_CS_DONE: cover property ($fell(st_reg.cs_busy));
  COV_PAR_ERR: cover property ($rose(st_reg.es[`DMS_ES_PE]));
endmodule
`default_nettype wire

// ---- inc/dms_params.svh ----
// register indices, field positions, reset values and timing counts
`ifndef DMS_PARAMS_SVH
`define DMS_PARAMS_SVH

// ----------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DMS_IDX_ASYNC 16'hff70
`define DMS_IDX_STATUS 16'hff71
`define DMS_IDX_CLOCKED 16'hff72
`define DMS_IDX_DATA 16'hff74
`define DMS_IDX_BAUD 16'hff76

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DMS_AM_TXE 7
`define DMS_AM_RXE 6
`define DMS_AM_PSH 5
`define DMS_AM_PSL 4
`define DMS_AM_CL 3
`define DMS_AM_SL 2
`define DMS_CM_EN 7
`define DMS_CM_DIR 2
`define DMS_CM_SRC 1
`define DMS_ES_PE 2
`define DMS_ES_FE 1
`define DMS_ES_OV 0

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define DMS_ASYNC_RST 8'h00
`define DMS_CLOCKED_RST 8'h00
`define DMS_TXS_RST 8'hff
`define DMS_BAUD_RST 8'h00
`define DMS_OS_LAST 4'hf
`define DMS_OS_MID 4'h7

`endif

// ---- inc/dms_pkg.sv ----
// types shared by the dual mode serial core
package dms_pkg;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PAR = 3'h2,
    RX_STOP = 3'h6
  } dms_rx_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } dms_sync_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } dms_baud_state_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rd;
    logic [7:0] am;
    logic [7:0] cm;
    logic [7:0] bg;
    logic [7:0] txs;
    logic [2:0] es;
    logic [7:0] rxb;
    logic rx_full;
    logic tx_busy;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_os;
    logic txd;
    dms_rx_state_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_idx;
    logic [7:0] rx_sh;
    logic rx_par;
    logic cs_busy;
    logic [3:0] cs_k;
    logic sck;
    logic sck_prev;
    logic so;
  } dms_state_t;

endpackage

// ---- rtl/dms_sync.sv ----
// two-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module dms_sync (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  import dms_pkg::*;

  dms_sync_state_t st_reg;
  dms_sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  // lines idle high, so reset to that level
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg <= 2'h3;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule
`default_nettype wire

// ---- rtl/dms_baud.sv ----
// baud tick divider: one tick every div_i+1 clocks while running
`timescale 1ns/1ps
`default_nettype none
module dms_baud (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [7:0] div_i,
  output logic tick_o
);
  import dms_pkg::*;

  dms_baud_state_t st_reg;
  dms_baud_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run_i) begin
      st_next.cnt = 8'h00;
    end else if (st_reg.cnt >= div_i) begin
      st_next.cnt = 8'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;
endmodule
`default_nettype wire

// ---- sim/dms_remote_model.sv ----
// remote serial peer: uart frame source and sink, clocked-mode slave
`timescale 1ns/1ps
`default_nettype none
module dms_remote_model (
  input wire logic clk_i,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic sck_i,
  input wire logic so_i,
  output logic si_o,
  output logic ext_sck_o
);
  logic [7:0] si_byte;
  logic [7:0] so_cap;
  logic si_dir;
  int rises;
  // a released uart line idles high
  initial begin
    txd_o = 1'b1;
    si_o = 1'b1;
    ext_sck_o = 1'b1;
    si_byte = 8'h00;
    si_dir = 1'b0;
    rises = 0;
    so_cap = 8'h00;
  end
  // ----------------------------------------------------------------
  // uart side: one bit is 16 clocks with the divisor at zero
  // ----------------------------------------------------------------
  task automatic bit_out(input logic v);
    txd_o <= v;
    repeat (16) @(posedge clk_i);
  endtask
  task automatic send(input logic [7:0] d, input int nb, input int haspar,
      input logic pbit, input int sb, input logic stopv);
    @(posedge clk_i);
    bit_out(1'b0);
    for (int i = 0; i < nb; i++) begin
      bit_out(d[i]);
    end
    if (haspar != 0) begin
      bit_out(pbit);
    end
    bit_out(stopv);
    if (sb == 2) begin
      bit_out(1'b1);
    end
    txd_o <= 1'b1;
  endtask
  // samples in mid-bit, starting from the falling start edge
  task automatic catch_frame(input int nb, input int haspar, input int sb,
      output logic [7:0] d, output logic p, output logic stp);
    d = 8'h00;
    p = 1'b0;
    stp = 1'b1;
    @(negedge rxd_i);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (16) @(posedge clk_i);
      d[i] = rxd_i;
    end
    if (haspar != 0) begin
      repeat (16) @(posedge clk_i);
      p = rxd_i;
    end
    for (int i = 0; i < sb; i++) begin
      repeat (16) @(posedge clk_i);
      stp = stp & rxd_i;
    end
  endtask
  // ----------------------------------------------------------------
  // clocked side: capture on rise, present next bit on fall
  // ----------------------------------------------------------------
  task automatic load(input logic [7:0] b, input logic dir);
    si_byte = b;
    si_dir = dir;
    rises = 0;
    si_o <= dir ? b[0] : b[7];
  endtask
  // external shift clock: eight pulses, four clocks per phase, idle high
  task automatic clock_out();
    repeat (8) begin
      repeat (4) @(posedge clk_i);
      ext_sck_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      ext_sck_o <= 1'b1;
    end
  endtask
  always @(posedge sck_i) begin
    so_cap <= {so_cap[6:0], so_i};
    rises <= rises + 1;
  end
  always @(negedge sck_i) begin
    if (rises > 0 && rises < 8) begin
      si_o <= si_dir ? si_byte[rises] : si_byte[7 - rises];
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// testbench: register, uart and clocked-mode checks of the serial core
`timescale 1ns/1ps
`default_nettype none
`include "dms_params.svh"
module tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] address = 16'h0000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic waitreq, txd, rxd, so, si, sck, sck_oe;
  logic ext_sck, sck_line;
  int fails = 0;
  int checks_done = 0;
  int seed = 75;
  always #50 ref_clk_i = ~ref_clk_i;
  dms_core i_dms_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .avs_address_i(address), .avs_read_i(rd), .avs_write_i(wr),
    .avs_byteenable_i(4'h1), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .async_receive_pin_i(rxd), .async_transmit_pin_o(txd),
    .clocked_data_in_i(si), .clocked_data_out_o(so),
    .serial_clock_pin_i(sck_line), .serial_clock_pin_o(sck),
    .serial_clock_pin_oe_o(sck_oe));
  // shared clock pin: the core drives it while enabled with the internal clock source, else the peer
  assign sck_line = sck_oe ? sck : ext_sck;
  dms_remote_model i_dms_remote_model (.clk_i(ref_clk_i), .rxd_i(txd),
    .txd_o(rxd), .sck_i(sck_line), .so_i(so), .si_o(si),
    .ext_sck_o(ext_sck));
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // request held until a rising edge sees waitrequest low; that edge
  // takes the write or the read data, and only then is it released
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    address <= a;
    wdata <= {24'h00_0000, d};
    wr <= 1'b1;
    do @(posedge ref_clk_i); while (waitreq !== 1'b0);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    address <= a;
    rd <= 1'b1;
    do @(posedge ref_clk_i); while (waitreq !== 1'b0);
    d = rdata[7:0];
    rd <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic logic par_of(input int pm, input logic [7:0] d);
    if (pm == 1) return 1'b0;
    if (pm == 2) return ~^d;
    return ^d;
  endfunction
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction
  task automatic rx_frame(input logic [7:0] d, input logic pb,
      input logic stopv);
    i_dms_remote_model.send(d, 8, 1, pb, 1, stopv);
    repeat (40) @(posedge ref_clk_i);
  endtask
  initial begin
    repeat (50000) @(posedge ref_clk_i);
    fails++;
    conclude();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [7:0] v, d, got, b;
    logic p, stp, hold;
    int pm, cl, sl;
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    bus_rd(`DMS_IDX_ASYNC, got); check(got, 8'h00);
    bus_rd(`DMS_IDX_CLOCKED, got); check(got, 8'h00);
    bus_rd(`DMS_IDX_STATUS, got); check(got, 8'h00);
    bus_rd(16'hff7e, got); check(got, 8'h00);
    // receive buffer content after reset is left unchecked
    bus_wr(`DMS_IDX_CLOCKED, 8'h86);
    bus_rd(`DMS_IDX_CLOCKED, got); check(got, 8'h86);
    check({7'h00, sck_oe}, 8'h01);
    bus_wr(`DMS_IDX_CLOCKED, 8'h84);
    @(negedge ref_clk_i);
    check({7'h00, sck_oe}, 8'h00);
    bus_wr(`DMS_IDX_CLOCKED, 8'h00);
    bus_wr(`DMS_IDX_STATUS, 8'h07);
    bus_rd(`DMS_IDX_STATUS, got); check(got, 8'h00);
    $display("test registers done");
    bus_wr(`DMS_IDX_BAUD, 8'h00);
    for (int k = 0; k < 16; k++) begin
      pm = k % 4;
      cl = (k / 4) % 2;
      sl = k / 8;
      bus_wr(`DMS_IDX_ASYNC, {2'b11, pm[1:0], cl[0], sl[0], 2'b00});
      v = 8'($random(seed));
      d = (cl != 0) ? v : {1'b0, v[6:0]};
      fork
        bus_wr(`DMS_IDX_DATA, v);
        i_dms_remote_model.catch_frame(cl ? 8 : 7, pm, sl + 1, got, p, stp);
      join
      check(got, d);
      check({7'h00, p}, {7'h00, (pm != 0) ? par_of(pm, d) : 1'b0});
      check({7'h00, stp}, 8'h01);
      v = 8'($random(seed));
      d = (cl != 0) ? v : {1'b0, v[6:0]};
      i_dms_remote_model.send(v, cl ? 8 : 7, pm, par_of(pm, d), sl + 1, 1'b1);
      repeat (40) @(posedge ref_clk_i);
      bus_rd(`DMS_IDX_DATA, got); check(got, d);
      bus_rd(`DMS_IDX_STATUS, got); check(got, 8'h00);
    end
    $display("test async formats done");
    bus_wr(`DMS_IDX_ASYNC, 8'he8);
    rx_frame(8'h5a, ~par_of(2, 8'h5a), 1'b1);
    bus_rd(`DMS_IDX_STATUS, got); check(got, 8'h04);
    bus_rd(`DMS_IDX_DATA, got);
    rx_frame(8'h3c, par_of(2, 8'h3c), 1'b0);
    bus_rd(`DMS_IDX_STATUS, got); check(got, 8'h02);
    bus_rd(`DMS_IDX_DATA, got);
    rx_frame(8'h11, par_of(2, 8'h11), 1'b1);
    rx_frame(8'h96, par_of(2, 8'h96), 1'b1);
    bus_rd(`DMS_IDX_STATUS, got); check(got, 8'h01);
    bus_rd(`DMS_IDX_DATA, got); check(got, 8'h96);
    bus_rd(`DMS_IDX_STATUS, got); check(got, 8'h00);
    $display("test receive errors done");
    // transmitter off: a data write must leave the line idle
    bus_wr(`DMS_IDX_ASYNC, 8'h48);
    bus_wr(`DMS_IDX_DATA, 8'h00);
    hold = 1'b1;
    repeat (300) begin
      @(negedge ref_clk_i);
      hold = hold & txd;
    end
    check({7'h00, hold}, 8'h01);
    $display("test transmit disable done");
    bus_wr(`DMS_IDX_ASYNC, 8'h00);
    bus_wr(`DMS_IDX_BAUD, 8'h03);
    // modes 0 and 1 use the internal clock, 2 and 3 the peer's clock
    for (int m = 0; m < 4; m++) begin
      v = 8'($random(seed));
      b = 8'($random(seed));
      @(posedge ref_clk_i);
      i_dms_remote_model.load(b, m[0]);
      bus_wr(`DMS_IDX_CLOCKED, {5'b10000, m[0], ~m[1], 1'b0});
      bus_wr(`DMS_IDX_DATA, v);
      if (m > 1) begin
        i_dms_remote_model.clock_out();
      end
      repeat (100) @(posedge ref_clk_i);
      check(i_dms_remote_model.so_cap, m[0] ? rev(v) : v);
      check({7'h00, sck}, 8'h01);
      bus_rd(`DMS_IDX_DATA, got); check(got, b);
      bus_wr(`DMS_IDX_CLOCKED, 8'h00);
    end
    $display("test clocked mode done");
    conclude();
  end
endmodule
`default_nettype wire
